// [core/lpm_ctrl.sv]
// Purpose: Idle and power-down control with power control register
// Assumes: Classic Wishbone slave, 32-bit data, byte data in lane 0
// Notes:   CPU, interrupt logic and port latches sit outside this block
//
// Added by the designer: the Wishbone slave port.

`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Power mode controller
// ----------------------------------------------------------------------
// Function
// - In idle the CPU is halted while peripherals keep their clock.
// - Idle leaves CPU state, RAM and registers untouched.
// - Writing the idle bit is the last instruction before the halt.
// - An enabled interrupt ends idle; the CPU resumes at its handler.
// - A hardware reset ends idle and restarts like power-on.
// - Power-down stops the oscillator; only RAM content is kept.
// - Only a hardware reset ends power-down; interrupts do not.
// - The power control register sits at register index 87h.
// - The register is reached as a whole byte, never by bit address.
// - Reset clears every defined bit of the power control register.
// - Layout: baud doubler, rsv, ALE quieting, rsv, flags, PD, idle.
// - Reserved bits read as no fixed value the bench may rely on.
// - Idle: strobes high; ports hold data, or P0 floats, P2 address.
// - Power-down: strobes low; ports hold data, P0 floats if external.
// - Reset pin high for 24 oscillator periods resets the device.
// - ALE quieting pulls the address latch strobe low instead.
// - External data moves still pulse the strobe under quieting.
// - External fetch or fetch past internal memory still pulses it.
module lpm_ctrl
	import lpm_pkg::*;
(
	// Clock and reset
	input wire logic MCLK_I,
	input wire logic RST_I,
	// Wishbone slave
	input wire logic [WB_ADR_W-1:0] ADR_I,
	input wire logic [31:0] DAT_I,
	output logic [31:0] DAT_O,
	input wire logic WE_I,
	input wire logic [3:0] SEL_I,
	input wire logic CYC_I,
	input wire logic STB_I,
	output logic ACK_O,
	// Pins
	input wire logic RST_PIN_I,
	input wire logic EXT_FETCH_SELECT_I,
	// CPU and interrupt side
	input wire logic IRQ_I,
	input wire logic EXTERNAL_DATA_MOVE_I,
	input wire logic PC_ABOVE_INTERNAL_I,
	input wire logic [1:0] SER_MODE_I,
	output logic CPU_HALT_O,
	output logic CPU_RESET_O,
	output logic OSC_STOP_O,
	output logic BAUD_DOUBLE_O,
	// Running bus values and port latches
	input wire logic [7:0] P0_BUS_I,
	input wire logic P0_BUS_OE_N_I,
	input wire logic [7:0] P2_BUS_I,
	input wire logic ALE_BUS_I,
	input wire logic PROG_FETCH_STROBE_BUS_N_I,
	input wire logic [7:0] P0_LATCH_I,
	input wire logic [7:0] P2_LATCH_I,
	input wire logic [7:0] ADDR_HI_I,
	// Pin drivers
	output logic [7:0] P0_O,
	output logic P0_OE_N_O,
	output logic [7:0] P2_O,
	output logic ALE_O,
	output logic PROG_FETCH_STROBE_N_O
);

	lpm_state_s s_reg;
	lpm_state_s s_next;
	logic hw_rst;
	logic req;
	logic hit_pwr;
	logic hit_status;
	logic [7:0] wr_byte;

	// ------------------------------------------------------------------
	// Reset pin qualification
	// ------------------------------------------------------------------
	lpm_rst_filter i_lpm_rst_filter (
		.clk_i(MCLK_I),
		.rst_i(RST_I),
		.pin_i(RST_PIN_I),
		.hw_rst_o(hw_rst)
	);

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	// Word decode only; the byte sits in lane 0
	assign req = CYC_I & STB_I & ~s_reg.ack;
	assign hit_pwr = (ADR_I == PWR_CTRL_ADR);
	assign hit_status = (ADR_I == STATUS_ADR);
	// Reserved bits are never stored, so they read back as zero
	assign wr_byte = (DAT_I[7:0] & PWR_WMASK)
		| (s_reg.pwr & ~PWR_WMASK);

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	// Register access, mode sequencing and pin multiplexing
	always_comb begin
		s_next = s_reg;
		s_next.ack = req;
		s_next.rdata = 8'h00;
		s_next.ext_meta = EXT_FETCH_SELECT_I;
		s_next.ext_sync = s_reg.ext_meta;
		s_next.boot = 1'b0;
		s_next.cpu_rst = hw_rst;

		// Fetch selection is caught at each reset
		if (s_reg.boot | hw_rst) begin
			s_next.ext_fetch = s_reg.ext_sync;
		end

		// Register reads
		if (req & ~WE_I) begin
			if (hit_pwr) begin
				s_next.rdata = s_reg.pwr;
			end else if (hit_status) begin
				s_next.rdata = {4'h0, hw_rst, s_reg.ext_fetch,
					s_reg.mode == MODE_PDOWN,
					s_reg.mode == MODE_IDLE};
			end
		end

		// Mode sequencing
		unique case (s_reg.mode)
			MODE_RUN: begin
				if (req & WE_I & SEL_I[0] & hit_pwr) begin
					s_next.pwr = lpm_pwr_s'(wr_byte);
					if (s_next.pwr.powerdown_request) begin
						s_next.mode = MODE_PDOWN;
					end else if (s_next.pwr.idle_request) begin
						s_next.mode = MODE_IDLE;
					end
				end
			end
			MODE_IDLE: begin
				// Register writes still land; CPU state is untouched
				if (req & WE_I & SEL_I[0] & hit_pwr) begin
					s_next.pwr = lpm_pwr_s'(wr_byte);
				end
				if (IRQ_I) begin
					s_next.pwr.idle_request = 1'b0;
					s_next.mode = MODE_RUN;
				end
			end
			MODE_PDOWN: begin
				// Writes are acknowledged but dropped; no wake source
				s_next.mode = MODE_PDOWN;
			end
		endcase

		// Hardware reset wins over every mode
		if (hw_rst) begin
			s_next.pwr = lpm_pwr_s'(PWR_RESET);
			s_next.mode = MODE_RUN;
		end

		s_next.halt = (s_next.mode != MODE_RUN);
		s_next.osc_stop = (s_next.mode == MODE_PDOWN);
		s_next.baud_x2 = s_next.pwr.baud_doubler
			& (SER_MODE_I != SER_MODE_0);

		// Pin multiplexing per mode
		unique case (s_next.mode)
			MODE_RUN: begin
				s_next.pins.p0_data = P0_BUS_I;
				s_next.pins.p0_oe_n = P0_BUS_OE_N_I;
				s_next.pins.p2_data = P2_BUS_I;
				s_next.pins.prog_fetch_strobe_n = PROG_FETCH_STROBE_BUS_N_I;
				if (s_next.pwr.ale_quieting & ~s_reg.ext_fetch
					& ~PC_ABOVE_INTERNAL_I & ~EXTERNAL_DATA_MOVE_I) begin
					s_next.pins.ale = 1'b0;
				end else begin
					s_next.pins.ale = ALE_BUS_I;
				end
			end
			MODE_IDLE: begin
				s_next.pins.ale = 1'b1;
				s_next.pins.prog_fetch_strobe_n = 1'b1;
				if (s_reg.ext_fetch) begin
					s_next.pins.p0_data = P0_LATCH_I;
					s_next.pins.p0_oe_n = 1'b1;
					s_next.pins.p2_data = ADDR_HI_I;
				end else begin
					s_next.pins.p0_data = P0_LATCH_I;
					s_next.pins.p0_oe_n = 1'b0;
					s_next.pins.p2_data = P2_LATCH_I;
				end
			end
			MODE_PDOWN: begin
				s_next.pins.ale = 1'b0;
				s_next.pins.prog_fetch_strobe_n = 1'b0;
				s_next.pins.p0_data = P0_LATCH_I;
				s_next.pins.p0_oe_n = s_reg.ext_fetch;
				s_next.pins.p2_data = P2_LATCH_I;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			s_reg <= '{
				pwr: lpm_pwr_s'(PWR_RESET),
				mode: MODE_RUN,
				ack: 1'b0,
				rdata: 8'h00,
				ext_meta: EXT_FETCH_SELECT_I, // Keeps syncing in reset
				ext_sync: s_reg.ext_meta, // Valid at first capture
				ext_fetch: 1'b0,
				boot: 1'b1,
				pins: '{p0_data: 8'hff, p0_oe_n: 1'b1,
					p2_data: 8'hff, ale: 1'b0,
					prog_fetch_strobe_n: 1'b1},
				halt: 1'b0,
				osc_stop: 1'b0,
				baud_x2: 1'b0,
				cpu_rst: 1'b1
			};
		end else begin
			s_reg <= s_next;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign ACK_O = s_reg.ack;
	assign DAT_O = {24'h000000, s_reg.rdata};
	assign CPU_HALT_O = s_reg.halt;
	assign CPU_RESET_O = s_reg.cpu_rst;
	assign OSC_STOP_O = s_reg.osc_stop;
	assign BAUD_DOUBLE_O = s_reg.baud_x2;
	assign P0_O = s_reg.pins.p0_data;
	assign P0_OE_N_O = s_reg.pins.p0_oe_n;
	assign P2_O = s_reg.pins.p2_data;
	assign ALE_O = s_reg.pins.ale;
	assign PROG_FETCH_STROBE_N_O = s_reg.pins.prog_fetch_strobe_n;

endmodule : lpm_ctrl

// [core/lpm_pkg.sv]
// Purpose: Shared constants and types for the low power mode controller
// Assumes: Oscillator clock and bus clock are the same 200 MHz clock
// Notes:   Register indices are word indices; byte address is index * 4

// ----------------------------------------------------------------------
// Package
// ----------------------------------------------------------------------
package lpm_pkg;

	// Clock and oscillator timing
	localparam int CLK_PERIOD_PS = 5000;
	localparam int OSC_PERIOD_PS = 5000;
	localparam int MCYCLE_OSC = 12;
	localparam int RST_MCYCLES = 2;
	// Reset pin hold time, in oscillator periods
	localparam int RST_HOLD_OSC = RST_MCYCLES * MCYCLE_OSC;
	// Same time in clock cycles, rounded up
	localparam int RST_HOLD_CYC =
		(RST_HOLD_OSC * OSC_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RST_CNT_W = 5;

	// Register map
	localparam int WB_ADR_W = 10;
	localparam logic [7:0] PWR_CTRL_IDX = 8'h87;
	localparam logic [7:0] STATUS_IDX = 8'h88;
	localparam logic [9:0] PWR_CTRL_ADR = {PWR_CTRL_IDX, 2'h0};
	localparam logic [9:0] STATUS_ADR = {STATUS_IDX, 2'h0};
	localparam logic [7:0] PWR_WMASK = 8'haf;
	localparam logic [7:0] PWR_RESET = 8'h00;
	localparam logic [1:0] SER_MODE_0 = 2'h0;

	// Operating modes
	typedef enum logic [2:0] {
		MODE_RUN = 3'b001,
		MODE_IDLE = 3'b010,
		MODE_PDOWN = 3'b100
	} lpm_mode_e;

	// Power control register, bit 7 first
	typedef struct packed {
		logic baud_doubler;
		logic rsv6;
		logic ale_quieting;
		logic rsv4;
		logic user_flag_1;
		logic user_flag_0;
		logic powerdown_request;
		logic idle_request;
	} lpm_pwr_s;

	// External bus pin group
	typedef struct packed {
		logic [7:0] p0_data;
		logic p0_oe_n;
		logic [7:0] p2_data;
		logic ale;
		logic prog_fetch_strobe_n;
	} lpm_bus_s;

	// Reset pin filter state
	typedef struct packed {
		logic [1:0] sync;
		logic [RST_CNT_W-1:0] cnt;
		logic active;
	} lpm_rst_s;

	// Main controller state
	typedef struct packed {
		lpm_pwr_s pwr;
		lpm_mode_e mode;
		logic ack;
		logic [7:0] rdata;
		logic ext_meta;
		logic ext_sync;
		logic ext_fetch;
		logic boot;
		lpm_bus_s pins;
		logic halt;
		logic osc_stop;
		logic baud_x2;
		logic cpu_rst;
	} lpm_state_s;

endpackage : lpm_pkg

// [core/lpm_rst_filter.sv]
// Purpose: Qualifies the reset pin: two machine cycles high make a reset
// Assumes: Pin is asynchronous to the clock
// Notes:   Output stays high while the pin stays high after qualification

`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Reset pin filter
// ----------------------------------------------------------------------
module lpm_rst_filter
	import lpm_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Pin and result
	input wire logic pin_i,
	output logic hw_rst_o
);

	localparam logic [RST_CNT_W-1:0] HOLD_LAST =
		RST_CNT_W'(RST_HOLD_CYC - 1);

	lpm_rst_s s_reg;
	lpm_rst_s s_next;

	// Synchronise pin and count how long it stays high
	always_comb begin
		s_next = s_reg;
		s_next.sync = {s_reg.sync[0], pin_i};
		if (s_reg.sync[1]) begin
			if (s_reg.cnt == HOLD_LAST) begin
				s_next.active = 1'b1;
			end else begin
				s_next.cnt = s_reg.cnt + RST_CNT_W'(1);
			end
		end else begin
			s_next.cnt = '0;
			s_next.active = 1'b0;
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign hw_rst_o = s_reg.active;

endmodule : lpm_rst_filter

// [sim/low_power_mode_control_tb.sv]
// Purpose: Self-checking bench of the power mode controller
// Assumes: Internal program memory first, external fetch selected later
// Notes:   Reserved bits are masked out of read compares
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin failures++; \
	$display("unexpected %s exp %h got %h", n, e, a); end end
module low_power_mode_control_tb
	import lpm_pkg::*;
;
	logic clk = 0, rst = 1, we = 0, cyc = 0, stb = 0;
	logic pin = 0, irq = 0, edm = 0, pca = 0, efs = 0;
	logic [23:0] lat_d = 24'h000000;
	logic [9:0] adr = 10'h000;
	logic [31:0] dat = 32'h0, rdo, rexp;
	logic [3:0] sel = 4'h0;
	logic [1:0] smode = 2'h0;
	logic [7:0] p0l = 8'h00, p2l = 8'h00, ahi = 8'h00, p0o, p2o;
	logic ack, halt, cres, osc, baud, p0oe, ale, psn;
	lpm_bus_s bus;
	logic [31:0] exp_q[$];
	integer seed = 52293, failures = 0, num_checks = 0, i, n;
	// Clock
	initial begin
		forever #2.5 clk = ~clk;
	end
	// Random port latch and address contents, with a one-edge copy
	always @(posedge clk) begin
		lat_d <= {p0l, p2l, ahi};
		{p0l, p2l, ahi} <= 24'($random(seed));
	end
	lpm_ext_mem i_lpm_ext_mem (.clk_i(clk), .rst_i(rst), .bus_o(bus));
	lpm_ctrl i_lpm_ctrl (.MCLK_I(clk), .RST_I(rst), .ADR_I(adr),
		.DAT_I(dat), .DAT_O(rdo), .WE_I(we), .SEL_I(sel), .CYC_I(cyc),
		.STB_I(stb), .ACK_O(ack), .RST_PIN_I(pin), .EXT_FETCH_SELECT_I(efs),
		.IRQ_I(irq), .EXTERNAL_DATA_MOVE_I(edm), .PC_ABOVE_INTERNAL_I(pca),
		.SER_MODE_I(smode), .CPU_HALT_O(halt), .CPU_RESET_O(cres),
		.OSC_STOP_O(osc), .BAUD_DOUBLE_O(baud), .P0_BUS_I(bus.p0_data),
		.P0_BUS_OE_N_I(bus.p0_oe_n), .P2_BUS_I(bus.p2_data),
		.ALE_BUS_I(bus.ale), .PROG_FETCH_STROBE_BUS_N_I(bus.prog_fetch_strobe_n),
		.P0_LATCH_I(p0l), .P2_LATCH_I(p2l), .ADDR_HI_I(ahi), .P0_O(p0o),
		.P0_OE_N_O(p0oe), .P2_O(p2o), .ALE_O(ale), .PROG_FETCH_STROBE_N_O(psn));
	task automatic tally_and_finish;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : tally_and_finish
	// One classic cycle, held until acknowledged
	task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
		int k;
		k = 0;
		@(posedge clk);
		{cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, 24'h0, d, 4'h1};
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 20);
		if (k >= 20) begin
			failures++;
			tally_and_finish();
		end
		{cyc, stb} <= 2'b00;
	endtask : wb
	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		exp_q.push_back({24'h0, e & 8'haf});
		wb(1'b0, a, 8'h00);
	endtask : rd
	task automatic hw_reset;
		pin <= 1'b1;
		repeat (40) @(posedge clk);
		`CHK("cpu reset", 1'b1, cres)
		pin <= 1'b0;
		repeat (8) @(posedge clk);
		`CHK("halt", 1'b0, halt)
		`CHK("osc stop", 1'b0, osc)
		rd(PWR_CTRL_ADR, 8'h00);
	endtask : hw_reset
	// Read answers against the oldest noted value
	always @(posedge clk) begin
		if (ack === 1'b1 && !we && exp_q.size() > 0) begin
			rexp = exp_q.pop_front();
			`CHK("read data", rexp, rdo & 32'hffffffaf)
		end
	end
	// Main sequence
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rd(PWR_CTRL_ADR, 8'h00);
		rd(10'h300, 8'h00);
		wb(1'b1, PWR_CTRL_ADR, 8'hac);
		rd(PWR_CTRL_ADR, 8'hac);
		for (i = 0; i < 4; i++) begin
			smode <= i[1:0];
			repeat (3) @(posedge clk);
			`CHK("baud", i != 0, baud)
		end
		for (i = 0; i < 12; i++) begin
			@(posedge clk);
			`CHK("quiet strobe", 1'b0, ale)
		end
		pca <= 1'b1;
		repeat (2) @(posedge clk);
		n = 0;
		for (i = 0; i < 12; i++) begin
			@(posedge clk);
			n += ale;
		end
		`CHK("strobe pulses", 2, n)
		pca <= 1'b0;
		for (i = 0; i < 30; i++) begin
			@(posedge clk);
			edm <= 1'($random(seed));
		end
		edm <= 1'b0;
		$display("run tests done");
		wb(1'b1, PWR_CTRL_ADR, 8'had);
		repeat (2) @(posedge clk);
		`CHK("halt", 1'b1, halt)
		`CHK("idle strobes", 2'b11, {ale, psn})
		`CHK("idle ports", {1'b0, lat_d[23:8]}, {p0oe, p0o, p2o})
		rd(STATUS_ADR, 8'h01);
		rd(PWR_CTRL_ADR, 8'had);
		irq <= 1'b1;
		@(posedge clk);
		irq <= 1'b0;
		repeat (2) @(posedge clk);
		`CHK("halt", 1'b0, halt)
		rd(PWR_CTRL_ADR, 8'hac);
		$display("idle tests done");
		wb(1'b1, PWR_CTRL_ADR, 8'haf);
		repeat (2) @(posedge clk);
		`CHK("osc stop", 1'b1, osc)
		`CHK("pd ports", {1'b0, lat_d[23:8]}, {p0oe, p0o, p2o})
		irq <= 1'b1;
		repeat (4) @(posedge clk);
		irq <= 1'b0;
		wb(1'b1, PWR_CTRL_ADR, 8'h00);
		`CHK("osc stop", 1'b1, osc)
		hw_reset();
		wb(1'b1, PWR_CTRL_ADR, 8'h01);
		efs <= 1'b1;
		hw_reset();
		$display("reset tests done");
		wb(1'b1, PWR_CTRL_ADR, 8'h20);
		n = 0;
		for (i = 0; i < 12; i++) begin
			@(posedge clk);
			n += ale;
		end
		`CHK("ext strobe pulses", 2, n)
		wb(1'b1, PWR_CTRL_ADR, 8'h21);
		repeat (2) @(posedge clk);
		`CHK("ext idle ports", {1'b1, lat_d[7:0]}, {p0oe, p2o})
		rd(STATUS_ADR, 8'h05);
		irq <= 1'b1;
		@(posedge clk);
		irq <= 1'b0;
		wb(1'b1, PWR_CTRL_ADR, 8'h02);
		repeat (2) @(posedge clk);
		`CHK("ext pd ports", {1'b1, lat_d[15:8]}, {p0oe, p2o})
		efs <= 1'b0;
		hw_reset();
		$display("external tests done");
		tally_and_finish();
	end
endmodule : low_power_mode_control_tb

// [sim/lpm_ext_mem.sv]
// Purpose: Running multiplexed bus of external program memory
// Assumes: Six clock phases per half machine cycle
// Notes:   Port 0 shows inverted address while released
`timescale 1ns/1ps
// --------
// Bus model
// --------
module lpm_ext_mem
	import lpm_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Running pin values
	output lpm_bus_s bus_o
);
	logic [2:0] ph_reg;
	logic [7:0] adr_reg;
	// Phase counter and fetch address
	always_ff @(posedge clk_i) begin
		if (rst_i || ph_reg == 3'h5)
			ph_reg <= 3'h0;
		else
			ph_reg <= ph_reg + 3'h1;
		adr_reg <= rst_i ? 8'h00 : adr_reg + 8'h01;
	end
	// Address latch pulse, then fetch strobe with released port 0
	always_comb begin
		bus_o.ale = ph_reg == 3'h0;
		bus_o.prog_fetch_strobe_n = !(ph_reg inside {3'h3, 3'h4});
		bus_o.p0_oe_n = ph_reg > 3'h1;
		bus_o.p0_data = bus_o.p0_oe_n ? ~adr_reg : adr_reg;
		bus_o.p2_data = adr_reg ^ 8'h5a;
	end
endmodule : lpm_ext_mem

// [sim/lpm_monitor.sv]
// Purpose: Mode and pin checks for the power mode controller
// Assumes: One clock domain, bound to lpm_ctrl
// Notes:   Pin checks wait one cycle after a mode output changes
`timescale 1ns/1ps
// --------
// Checker
// --------
module lpm_monitor
	import lpm_pkg::*;
(
	// Clock, reset and bus
	input wire logic MCLK_I,
	input wire logic RST_I,
	input wire logic [WB_ADR_W-1:0] ADR_I,
	input wire logic [31:0] DAT_I,
	input wire logic WE_I,
	input wire logic [3:0] SEL_I,
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic ACK_O,
	// Pins and mode outputs
	input wire logic RST_PIN_I,
	input wire logic IRQ_I,
	input wire logic EXTERNAL_DATA_MOVE_I,
	input wire logic ALE_BUS_I,
	input wire logic [7:0] P2_LATCH_I,
	input wire logic CPU_HALT_O,
	input wire logic CPU_RESET_O,
	input wire logic OSC_STOP_O,
	input wire logic [7:0] P2_O,
	input wire logic ALE_O,
	input wire logic PROG_FETCH_STROBE_N_O
);
	logic [5:0] pin_cnt;
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (RST_I);
	// Counts cycles the reset pin has stayed high
	always_ff @(posedge MCLK_I) begin
		if (RST_I || !RST_PIN_I)
			pin_cnt <= 6'h00;
		else if (pin_cnt != 6'h3f)
			pin_cnt <= pin_cnt + 6'h01;
	end
	// Steps shared by the properties
	sequence s_wr;
		CYC_I && STB_I && WE_I && !ACK_O && SEL_I[0] && ADR_I == PWR_CTRL_ADR;
	endsequence
	sequence s_run;
		!CPU_HALT_O && !CPU_RESET_O;
	endsequence
	AST_IDLE_ENTRY:
		assert property ((s_wr ##0 DAT_I[1:0] == 2'h1 && !IRQ_I &&
			!CPU_HALT_O) |=> CPU_HALT_O && !OSC_STOP_O) else $error("idle");
	AST_PD_ENTRY:
		assert property ((s_wr ##0 DAT_I[1] && !CPU_HALT_O) |=>
			OSC_STOP_O && CPU_HALT_O) else $error("power-down entry");
	AST_IDLE_WAKE:
		assert property (CPU_HALT_O && !OSC_STOP_O && IRQ_I |=> !CPU_HALT_O)
		else $error("idle wake");
	AST_IDLE_HOLD:
		assert property (CPU_HALT_O && !IRQ_I && !RST_PIN_I && !CYC_I
			|=> CPU_HALT_O) else $error("halt lost");
	AST_PD_NO_WAKE:
		assert property ($fell(OSC_STOP_O) |-> $past(RST_PIN_I))
		else $error("power-down left");
	AST_PD_PINS:
		assert property (OSC_STOP_O ##1 OSC_STOP_O |-> !ALE_O &&
			!PROG_FETCH_STROBE_N_O && P2_O == $past(P2_LATCH_I))
		else $error("power-down pins");
	AST_MOVE_ALE:
		assert property (s_run ##0 EXTERNAL_DATA_MOVE_I ##1 s_run |->
			ALE_O == $past(ALE_BUS_I)) else $error("move strobe");
	AST_HW_RESET:
		assert property (pin_cnt == 6'h1e |-> CPU_RESET_O)
		else $error("pin reset");
endmodule : lpm_monitor
bind lpm_ctrl lpm_monitor i_lpm_monitor (.MCLK_I, .RST_I, .ADR_I, .DAT_I,
	.WE_I, .SEL_I, .CYC_I, .STB_I, .ACK_O, .RST_PIN_I, .IRQ_I,
	.EXTERNAL_DATA_MOVE_I, .ALE_BUS_I, .P2_LATCH_I, .CPU_HALT_O,
	.CPU_RESET_O, .OSC_STOP_O, .P2_O, .ALE_O, .PROG_FETCH_STROBE_N_O);
